// ==== verilog/urm_pkg.sv ====
// constants and carrier types for the serial channel register set
// assumes one clock; the serial shifter and baud timer live outside
// How it works
// RULE_01 - enable bit 0 gates received data
// RULE_02 - enable bit 1 gates holding empty
// RULE_03 - enable bit 2 gates line errors
// RULE_04 - enable bit 3 gates modem changes
// RULE_05 - enable bits 4-7 ignored, read zero
// RULE_06 - all enables clear keeps interrupt quiet
// RULE_07 - any enabled pending source raises interrupt
// RULE_08 - data bit 0 is first serial bit
// RULE_09 - line control top bit selects divisor
// RULE_10 - three address lines pick eight offsets
// RULE_11 - identification bit 0 low when pending
// RULE_12 - priority: line, rx data, tx, modem
// RULE_13 - scratch byte stores and returns writes
package urm_pkg;
    // register offsets on the three address lines
    localparam logic [2:0] OFS_DATA      = 3'h0;
    localparam logic [2:0] OFS_ENABLE    = 3'h1;
    localparam logic [2:0] OFS_IDENT     = 3'h2;
    localparam logic [2:0] OFS_LINE_CTL  = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
    localparam logic [2:0] OFS_LINE_STAT = 3'h5;
    localparam logic [2:0] OFS_MODEM_ST  = 3'h6;
    localparam logic [2:0] OFS_SCRATCH   = 3'h7;

    // interrupt enable bit positions, then the line control divisor select bit
    localparam int IE_RX  = 0;
    localparam int IE_TX  = 1;
    localparam int IE_LS  = 2;
    localparam int IE_MS  = 3;
    localparam int DIVISOR_SELECT_BIT = 7;

    // values after reset
    localparam logic [3:0] IER_RESET   = 4'h0;
    localparam logic [7:0] LCR_RESET   = 8'h00;
    localparam logic [4:0] MCR_RESET   = 5'h00;
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam logic [7:0] IIR_NONE    = 8'h01;

    // identification codes in bits 2..0
    localparam logic [2:0] ID_NONE = 3'h1;
    localparam logic [2:0] ID_LS   = 3'h6;
    localparam logic [2:0] ID_RX   = 3'h4;
    localparam logic [2:0] ID_TX   = 3'h2;
    localparam logic [2:0] ID_MS   = 3'h0;

    // one received character with its error flags from the shifter
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parity_err;
        logic       framing_err;
        logic       break_seen;
    } urm_rx_char_t;

    // modem inputs, active high
    typedef struct packed {
        logic dcd;
        logic ri;
        logic dsr;
        logic cts;
    } urm_modem_in_t;

    // character format handed to the shifter
    typedef struct packed {
        logic       set_break;
        logic       stick_parity;
        logic       even_parity;
        logic       parity_en;
        logic       stop_bits;
        logic [1:0] word_len;
    } urm_line_cfg_t;
endpackage : urm_pkg

// ==== verilog/urm_serial_regs.sv ====
// register set and interrupt logic of one asynchronous serial channel
// assumes synchronous one-cycle read/write strobes from the host side
// and a shifter that hands over characters with a valid pulse
`timescale 1ns/10ps
module urm_serial_regs
    import urm_pkg::*;
(
    input  wire logic          clk,                   // 100 MHz clock
    input  wire logic          nrst,                  // async reset
    input  wire logic          ce,                    // clock enable
    input  wire logic [2:0]    addr,                  // register offset
    input  wire logic          rd_strobe,             // read, one cycle
    input  wire logic          wr_strobe,             // write, one cycle
    input  wire logic [7:0]    wr_data,               // write byte
    output logic      [7:0]    rd_data,               // read byte, reg
    output logic               interrupt_request_out, // interrupt, high
    input  urm_rx_char_t       rx_char,               // from shifter
    input  wire logic          tx_take,               // shifter took byte
    input  wire logic          tx_shift_idle,         // shifter empty
    output logic               tx_valid,              // byte waiting
    output logic      [7:0]    tx_data,               // byte to send
    output urm_line_cfg_t      line_cfg,              // char format
    output logic      [15:0]   baud_divisor,          // divisor latch
    input  urm_modem_in_t      modem_in,              // modem lines
    output logic               dtr_n,                 // terminal ready
    output logic               rts_n,                 // request to send
    output logic               out1_n,                // user output 1
    output logic               out2_n,                // user output 2
    output logic               loop_mode              // loopback request
);

    logic [3:0] ier_reg;
    logic [7:0] lcr_reg;
    logic [4:0] mcr_reg;
    logic [7:0] scr_reg;
    logic [7:0] dll_reg;
    logic [7:0] dlm_reg;
    logic [7:0] rbr_reg;
    logic [7:0] thr_reg;
    logic       data_ready_reg;
    logic [3:0] err_reg;       // break, framing, parity, overrun
    logic       tx_holding_empty_reg;
    logic       tx_holding_empty_pend_reg;
    logic [3:0] modem_prev_reg;
    logic       prev_ok_reg;
    logic [3:0] delta_reg;
    logic [7:0] rd_data_reg;
    logic       divisor_access_select;
    logic [3:0] pend;
    logic [3:0] en_pend;
    logic [2:0] cur_id;
    logic       rd_go;
    logic       wr_go;

    // highest enabled source wins the identification code
    function automatic logic [2:0] ident_of(input logic [3:0] p);
        if (p[IE_LS])      ident_of = ID_LS;
        else if (p[IE_RX]) ident_of = ID_RX;
        else if (p[IE_TX]) ident_of = ID_TX;
        else if (p[IE_MS]) ident_of = ID_MS;
        else               ident_of = ID_NONE;
    endfunction

    // true when a strobe hits a given offset
    function automatic logic hit(input logic go, input logic [2:0] a,
                                 input logic [2:0] ofs);
        hit = go && (a == ofs);
    endfunction

    assign rd_go = rd_strobe && ce;
    assign wr_go = wr_strobe && ce;
    assign divisor_access_select = lcr_reg[DIVISOR_SELECT_BIT]; // RULE_09

    // decoded accesses; offsets 0 and 1 swap meaning under the select
    logic rd_rbr, wr_thr, wr_ier, rd_iir, rd_lsr, rd_msr;
    logic wr_dll, wr_dlm;
    assign rd_rbr = hit(rd_go, addr, OFS_DATA) && !divisor_access_select;
    assign wr_thr = hit(wr_go, addr, OFS_DATA) && !divisor_access_select;
    assign wr_ier = hit(wr_go, addr, OFS_ENABLE) && !divisor_access_select;
    assign wr_dll = hit(wr_go, addr, OFS_DATA) && divisor_access_select;
    assign wr_dlm = hit(wr_go, addr, OFS_ENABLE) && divisor_access_select;
    assign rd_iir = hit(rd_go, addr, OFS_IDENT);
    assign rd_lsr = hit(rd_go, addr, OFS_LINE_STAT);
    assign rd_msr = hit(rd_go, addr, OFS_MODEM_ST);

    // software-written configuration
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ier_reg <= IER_RESET;
            lcr_reg <= LCR_RESET;
            mcr_reg <= MCR_RESET;
            scr_reg <= BYTE_RESET;
            dll_reg <= BYTE_RESET;
            dlm_reg <= BYTE_RESET;
        end else begin
            if (wr_ier)
                ier_reg <= wr_data[3:0];        // RULE_05
            if (hit(wr_go, addr, OFS_LINE_CTL))
                lcr_reg <= wr_data;
            if (hit(wr_go, addr, OFS_MODEM_CTL))
                mcr_reg <= wr_data[4:0];
            if (hit(wr_go, addr, OFS_SCRATCH))
                scr_reg <= wr_data;             // RULE_13
            if (wr_dll)
                dll_reg <= wr_data;             // RULE_09
            if (wr_dlm)
                dlm_reg <= wr_data;             // RULE_09
        end
    end

    // receive side; a new character beats a read in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rbr_reg        <= BYTE_RESET;
            data_ready_reg <= 1'b0;
            err_reg        <= 4'h0;
        end else if (ce) begin
            if (rx_char.valid) begin
                rbr_reg        <= rx_char.data; // RULE_08
                data_ready_reg <= 1'b1;
            end else if (rd_rbr) begin
                data_ready_reg <= 1'b0;
            end
            // overrun only if the old byte is not being read right now
            err_reg <= (rd_lsr ? 4'h0 : err_reg) |
                       ({4{rx_char.valid}} &
                        {rx_char.break_seen, rx_char.framing_err,
                         rx_char.parity_err, data_ready_reg && !rd_rbr});
        end
    end

    // transmit holding; a host write and a take together leave it full
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            thr_reg  <= BYTE_RESET;
            tx_holding_empty_reg <= 1'b1;
        end else if (ce) begin
            if (wr_thr) begin
                thr_reg  <= wr_data;            // RULE_08
                tx_holding_empty_reg <= 1'b0;
            end else if (tx_take) begin
                tx_holding_empty_reg <= 1'b1;
            end
        end
    end

    // holding-empty interrupt: set on emptying, cleared by a write or
    // by reading identification while it is the reported source
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            tx_holding_empty_pend_reg <= 1'b0;
        else if (ce) begin
            if (tx_take && !wr_thr && !tx_holding_empty_reg)
                tx_holding_empty_pend_reg <= 1'b1;
            else if (wr_thr || (rd_iir && cur_id == ID_TX))
                tx_holding_empty_pend_reg <= 1'b0;
        end
    end

    // modem change detect; first sample after reset only primes history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modem_prev_reg <= 4'h0;
            prev_ok_reg    <= 1'b0;
            delta_reg      <= 4'h0;
        end else if (ce) begin
            modem_prev_reg <= modem_in;
            prev_ok_reg    <= 1'b1;
            // ring reports its trailing edge only
            delta_reg <= (rd_msr ? 4'h0 : delta_reg) |
                ({4{prev_ok_reg}} &
                 {modem_in.dcd ^ modem_prev_reg[3],
                  !modem_in.ri && modem_prev_reg[2],
                  modem_in.dsr ^ modem_prev_reg[1],
                  modem_in.cts ^ modem_prev_reg[0]});
        end
    end

    // pending sources gated by their enables
    assign pend[IE_RX] = data_ready_reg;
    assign pend[IE_TX] = tx_holding_empty_pend_reg;
    assign pend[IE_LS] = |err_reg;
    assign pend[IE_MS] = |delta_reg;
    assign en_pend = pend & ier_reg;            // RULE_01 RULE_02 RULE_03 RULE_04
    assign cur_id  = ident_of(en_pend);         // RULE_12
    assign interrupt_request_out = |en_pend;    // RULE_06 RULE_07

    // read data is captured at the strobe and held until the next read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rd_data_reg <= BYTE_RESET;
        else if (rd_go) begin
            case (addr)                         // RULE_10
                OFS_DATA:
                    rd_data_reg <= divisor_access_select ? dll_reg : rbr_reg;
                OFS_ENABLE:
                    rd_data_reg <= divisor_access_select ? dlm_reg
                                   : {4'h0, ier_reg};       // RULE_05
                OFS_IDENT:     rd_data_reg <= {5'h00, cur_id}; // RULE_11
                OFS_LINE_CTL:  rd_data_reg <= lcr_reg;
                OFS_MODEM_CTL: rd_data_reg <= {3'h0, mcr_reg};
                OFS_LINE_STAT:
                    rd_data_reg <= {1'b0, tx_holding_empty_reg && tx_shift_idle,
                                    tx_holding_empty_reg, err_reg, data_ready_reg};
                OFS_MODEM_ST:  rd_data_reg <= {modem_in, delta_reg};
                OFS_SCRATCH:   rd_data_reg <= scr_reg;  // RULE_13
                default:       rd_data_reg <= BYTE_RESET;
            endcase
        end
    end

    assign rd_data      = rd_data_reg;
    assign tx_valid     = !tx_holding_empty_reg;
    assign tx_data      = thr_reg;
    assign baud_divisor = {dlm_reg, dll_reg};
    assign line_cfg     = lcr_reg[6:0];
    // modem outputs idle high after reset; loop_mode idles low
    assign dtr_n        = !mcr_reg[0];
    assign rts_n        = !mcr_reg[1];
    assign out1_n       = !mcr_reg[2];
    assign out2_n       = !mcr_reg[3];
    assign loop_mode    = mcr_reg[4];

    // checks on the interrupt path and register map
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_ier_high_zero: assert property (              // RULE_05
        rd_go && addr == OFS_ENABLE && !divisor_access_select
        |=> rd_data[7:4] == 4'h0)
        else $error("enable register upper bits not zero");
    a_rx_irq_gate: assert property (                // RULE_01
        data_ready_reg && ier_reg[IE_RX] |-> interrupt_request_out)
        else $error("enabled rx data did not interrupt");
    a_tx_irq_gate: assert property (                // RULE_02
        tx_holding_empty_pend_reg && ier_reg[IE_TX] |-> interrupt_request_out)
        else $error("enabled tx empty did not interrupt");
    a_ls_irq_gate: assert property (                // RULE_03
        ce && rx_char.valid && rx_char.parity_err && ier_reg[IE_LS]
        && !rd_lsr && !wr_ier |=> interrupt_request_out)
        else $error("enabled line error did not interrupt");
    a_ms_irq_gate: assert property (                // RULE_04
        (|delta_reg) && ier_reg[IE_MS] |-> interrupt_request_out)
        else $error("enabled modem change did not interrupt");
    a_irq_all_masked: assert property (             // RULE_06
        ier_reg == 4'h0 |-> !interrupt_request_out)
        else $error("interrupt raised with all enables clear");
    a_irq_has_cause: assert property (              // RULE_07
        interrupt_request_out |->
            (data_ready_reg && ier_reg[IE_RX]) ||
            (tx_holding_empty_pend_reg && ier_reg[IE_TX]) ||
            ((|err_reg) && ier_reg[IE_LS]) ||
            ((|delta_reg) && ier_reg[IE_MS]))
        else $error("interrupt without enabled pending source");
    a_ident_pending: assert property (              // RULE_11
        rd_go && addr == OFS_IDENT
        |=> rd_data[0] == !$past(interrupt_request_out))
        else $error("identification bit 0 wrong");
    a_ident_order: assert property (                // RULE_12
        rd_go && addr == OFS_IDENT && err_reg != 4'h0 && ier_reg[IE_LS]
        |=> rd_data[2:0] == ID_LS)
        else $error("line status not reported first");
    a_divisor_write: assert property (              // RULE_09
        wr_go && addr == OFS_DATA && divisor_access_select
        |=> baud_divisor[7:0] == $past(wr_data) && $stable(tx_data))
        else $error("divisor select did not redirect write");
    a_scratch_echo: assert property (               // RULE_13
        wr_go && addr == OFS_SCRATCH ##1 !(wr_go && addr == OFS_SCRATCH)
        ##1 rd_go && addr == OFS_SCRATCH
        |=> rd_data == $past(wr_data, 3))
        else $error("scratch byte not returned");
    a_rx_lsb_first: assert property (               // RULE_08
        ce && rx_char.valid |=> rbr_reg[0] == $past(rx_char.data[0]))
        else $error("receive bit 0 misplaced");

    c_rx_irq: cover property (data_ready_reg && ier_reg[IE_RX]);
    c_tx_cleared: cover property (tx_holding_empty_pend_reg ##1 !tx_holding_empty_pend_reg);
    c_ls_over_rx: cover property (en_pend[IE_LS] && en_pend[IE_RX]);
    c_modem_delta: cover property (delta_reg != 4'h0);

endmodule // urm_serial_regs

// ==== testbench/urm_far_model.sv ====
// shifter-side model: takes held bytes, hands in received characters
// assumes the register block's handshake on clk, async reset on nrst
`timescale 1ns/10ps
module urm_far_model
    import urm_pkg::*;
(
    input  wire logic       clk,           // system clock
    input  wire logic       nrst,          // async reset, low
    input  wire logic       stall,         // hold off taking bytes
    input  wire logic       tx_valid,      // byte waiting
    input  wire logic [7:0] tx_data,       // byte to send
    output logic            tx_take,       // took the byte, pulse
    output logic            tx_shift_idle, // shifter empty
    output urm_rx_char_t    rx_char,       // received character
    output logic [7:0]      tx_last        // last byte taken
);
    logic [2:0] busy_reg; // shift time left
    assign tx_shift_idle = (busy_reg == 3'h0);
    // one byte per free slot; stays busy as if shifting it out
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_take <= 1'b0;
            busy_reg <= 3'h0;
            tx_last <= 8'h00;
        end else if (tx_valid && !stall && !tx_take && tx_shift_idle) begin
            tx_take <= 1'b1;
            busy_reg <= 3'h4;
            tx_last <= tx_data; // bit 0 leaves first
        end else begin
            tx_take <= 1'b0;
            busy_reg <= (busy_reg == 3'h0) ? 3'h0 : busy_reg - 3'h1;
        end
    end
    initial rx_char = '0;
    // one-cycle valid; data inverted afterwards so stale bytes show
    task automatic send(input logic [7:0] b, input logic pe);
        @(posedge clk);
        rx_char <= {1'b1, b, pe, 2'h0};
        @(posedge clk);
        rx_char <= {1'b0, ~b, 3'h0};
    endtask
endmodule // urm_far_model

// ==== testbench/uart_register_map_irq_enable_bench.sv ====
// self-checking bench for the serial channel register set
// assumes urm_pkg and the shifter-side model urm_far_model
`timescale 1ns/10ps
module uart_register_map_irq_enable_bench;
    import urm_pkg::*;
    logic          clk, nrst, ce, rd_strobe, wr_strobe, stall;
    logic          irq, tx_take, tx_shift_idle, tx_valid, loop_mode;
    logic          dtr_n, rts_n, out1_n, out2_n;
    logic [2:0]    addr;
    logic [7:0]    wr_data, rd_data, tx_data, tx_last, d, v, w;
    logic [15:0]   baud_divisor;
    urm_rx_char_t  rx_char;
    urm_modem_in_t modem_in;
    urm_line_cfg_t line_cfg;
    int            err_total, comparisons, i;

    urm_serial_regs u_dut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr),
        .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wr_data(wr_data),
        .rd_data(rd_data), .interrupt_request_out(irq), .rx_char(rx_char),
        .tx_take(tx_take), .tx_shift_idle(tx_shift_idle),
        .tx_valid(tx_valid), .tx_data(tx_data), .line_cfg(line_cfg),
        .baud_divisor(baud_divisor), .modem_in(modem_in), .dtr_n(dtr_n),
        .rts_n(rts_n), .out1_n(out1_n), .out2_n(out2_n),
        .loop_mode(loop_mode));
    urm_far_model u_far (.clk(clk), .nrst(nrst), .stall(stall),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_take(tx_take),
        .tx_shift_idle(tx_shift_idle), .rx_char(rx_char),
        .tx_last(tx_last));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask

    // strobes last one cycle; result sampled once the edge settles
    task automatic wr(input logic [2:0] a, input logic [7:0] b);
        @(posedge clk);
        addr <= a;
        wr_data <= b;
        wr_strobe <= 1'b1;
        @(posedge clk);
        wr_strobe <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic rc(input logic [2:0] a, input logic [7:0] e);
        rd(a);
        chk(d, e);
    endtask

    // expected identification from enabled pending {ms,ls,tx,rx}
    function automatic logic [7:0] ident(input logic [3:0] p);
        if (p[IE_LS]) return {5'h00, ID_LS};
        if (p[IE_RX]) return {5'h00, ID_RX};
        if (p[IE_TX]) return {5'h00, ID_TX};
        if (p[IE_MS]) return {5'h00, ID_MS};
        return IIR_NONE;
    endfunction

    // bounded wait for the model to take the held byte
    task automatic wait_taken();
        for (i = 0; i < 20 && tx_valid !== 1'b0; i++) @(posedge clk);
        if (tx_valid !== 1'b0) begin
            err_total++;
            $display("[FAIL] %0t holding byte never taken", $time);
            stop_test();
        end
        @(posedge clk);
        #1;
    endtask

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        addr = 3'h0;
        rd_strobe = 1'b0;
        wr_strobe = 1'b0;
        wr_data = 8'h00;
        stall = 1'b1;
        modem_in = '0;
        err_total = 0;
        comparisons = 0;
        void'($urandom(32'hB182BB35));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rc(OFS_IDENT, IIR_NONE);
        rc(OFS_ENABLE, 8'h00);
        rc(OFS_LINE_STAT, 8'h60);
        chk({irq, dtr_n, rts_n, out1_n, out2_n}, 5'h0F);
        // random bytes through scratch and enable; upper enables drop
        for (int k = 0; k < 6; k++) begin
            v = 8'($urandom);
            wr(OFS_SCRATCH, v);
            rc(OFS_SCRATCH, v);
            wr(OFS_ENABLE, v);
            rc(OFS_ENABLE, {4'h0, v[3:0]});
            wr(OFS_IDENT, v);
            rc(OFS_IDENT, IIR_NONE);
        end
        wr(OFS_ENABLE, 8'h00);
        // frozen clock enable must drop the write
        @(posedge clk);
        ce <= 1'b0;
        wr(OFS_SCRATCH, ~v);
        @(posedge clk);
        ce <= 1'b1;
        rc(OFS_SCRATCH, v);
        // divisor bytes behind the select bit, then back to data view
        wr(OFS_LINE_CTL, 8'h80);
        v = 8'($urandom);
        w = 8'($urandom);
        wr(OFS_DATA, v);
        wr(OFS_ENABLE, w);
        chk(baud_divisor, {w, v});
        rc(OFS_DATA, v);
        rc(OFS_ENABLE, w);
        wr(OFS_LINE_CTL, 8'h1B);
        chk(line_cfg, 7'h1B);
        rc(OFS_ENABLE, 8'h00);
        chk(tx_valid, 1'b0);
        wr(OFS_MODEM_CTL, 8'h15);
        chk({loop_mode, out2_n, out1_n, rts_n, dtr_n}, 5'h1A);
        rc(OFS_MODEM_CTL, 8'h15);
        // transmit: held byte, then empty interrupt after the take
        v = 8'($urandom);
        wr(OFS_DATA, v);
        chk({tx_valid, tx_data}, {1'b1, v});
        wr(OFS_ENABLE, 8'h02);
        chk(irq, 1'b0);
        @(posedge clk);
        stall <= 1'b0;
        wait_taken();
        chk(tx_last, v);
        chk(irq, 1'b1);
        wr(OFS_ENABLE, 8'h00);
        chk(irq, 1'b0);
        rc(OFS_IDENT, IIR_NONE);
        wr(OFS_ENABLE, 8'h02);
        rc(OFS_IDENT, ident(4'h2));
        chk(irq, 1'b0);
        // receive: data interrupt, masked and unmasked
        v = 8'($urandom);
        u_far.send(v, 1'b0);
        #1;
        chk(irq, 1'b0);
        wr(OFS_ENABLE, 8'h01);
        chk(irq, 1'b1);
        rc(OFS_DATA, v);
        chk(irq, 1'b0);
        // modem change masked until bit 3 set
        @(posedge clk);
        modem_in.cts <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(irq, 1'b0);
        wr(OFS_ENABLE, 8'h08);
        chk(irq, 1'b1);
        rc(OFS_MODEM_ST, 8'h11);
        chk(irq, 1'b0);
        // all four pending at once, cleared in priority order
        @(posedge clk);
        stall <= 1'b1;
        modem_in.dsr <= 1'b1;
        wr(OFS_DATA, 8'($urandom));
        w = 8'($urandom);
        u_far.send(w, 1'b1);
        wr(OFS_ENABLE, 8'h04);
        chk(irq, 1'b1);
        @(posedge clk);
        stall <= 1'b0;
        wait_taken();
        wr(OFS_ENABLE, 8'hFF);
        rc(OFS_IDENT, ident(4'hF));
        rc(OFS_LINE_STAT, 8'h65);
        rc(OFS_IDENT, ident(4'hB));
        rc(OFS_DATA, w);
        rc(OFS_IDENT, ident(4'hA));
        rc(OFS_IDENT, ident(4'h8));
        chk(irq, 1'b1);
        rc(OFS_MODEM_ST, 8'h32);
        rc(OFS_IDENT, IIR_NONE);
        chk(irq, 1'b0);
        // unread byte overrun by the next; ring reports its fall only
        @(posedge clk);
        modem_in.ri <= 1'b1;
        u_far.send(v, 1'b0);
        u_far.send(w, 1'b1);
        #1;
        chk(irq, 1'b1);
        rc(OFS_LINE_STAT, 8'h67);
        rc(OFS_DATA, w);
        rc(OFS_MODEM_ST, 8'h70);
        @(posedge clk);
        modem_in.ri <= 1'b0;
        repeat (2) @(posedge clk);
        rc(OFS_IDENT, ident(4'h8));
        rc(OFS_MODEM_ST, 8'h34);
        rc(OFS_IDENT, IIR_NONE);
        stop_test();
    end
endmodule // uart_register_map_irq_enable_bench
